// file: inc/positioner_cfg_defs.vh
// Purpose: constants of the positioner switch configuration decoder
// Assumes: switch bit 0 is switch position 1 of each bank
// Notes: register indices are word offsets on the plain register port
//
// Contract
// - switches sampled once after reset, then held
// - micro-step code selects division 1 to 250
// - run current code selects 0.23 to 0.75 A
// - standstill code selects 27 to 90 percent
// - standstill code defaults to 5, half current
// - two baud bits select 4800 to 38400
// - two delimiter bits select CR/LF terminator
// - write protect refuses position memory writes
// - knob lock blocks front-panel knob steps; knob direction still passes
// - speed boost multiplies maximum speed by 1.5
// - slow speed divides maximum speed by ten
// - knob reverse inverts stage movement direction
// - backlash reverse inverts compensation direction
// - origin polarity selects separate or joined sensors
`ifndef POSITIONER_CFG_DEFS_VH
`define POSITIONER_CFG_DEFS_VH

// -------------------------------------------------
// switch bank a fields
// -------------------------------------------------
`define SWA_BAUD1 0
`define SWA_BAUD2 1
`define SWA_DELIM1 2
`define SWA_DELIM2 3
`define SWA_MEM_PROTECT 6
`define SWA_KNOB_LOCK 7
`define SWA_KEEP_MASK 8'hCF

// -------------------------------------------------
// switch bank b fields
// -------------------------------------------------
`define SWB_BOOST 0
`define SWB_SLOW 1
`define SWB_KNOB_REV 2
`define SWB_BACKLASH_REV 3
`define SWB_ORIGIN_POL 4
`define SWB_KEEP_MASK 8'h1F

// -------------------------------------------------
// speed scaling
// -------------------------------------------------
`define SPEED_SLOW_DIV 5'h14

// -------------------------------------------------
// reset values
// -------------------------------------------------
`define STOP_CODE_DEFAULT 4'h5

// -------------------------------------------------
// register indices
// -------------------------------------------------
`define REG_SWITCH 4'h0
`define REG_SELECT 4'h1
`define REG_DECODE 4'h2
`define REG_SPEED_BASE 4'h3
`define REG_SPEED_OUT 4'h4
`define REG_STATUS 4'h5

`endif

// file: verilog/positioner_switch_config_decoder.v
// Purpose: decode positioner configuration switches and selectors
// Assumes: switch and request inputs synchronous to core_clk_i
// Notes: settings are frozen at the first edge after reset release
`timescale 1ns/1ps
`default_nettype none
`include "positioner_cfg_defs.vh"

module positioner_switch_config_decoder #(
  parameter SPEED_W = 16
) (
  // clock and reset
  input wire core_clk_i,
  input wire rstn_i,
  // manual switches
  input wire [7:0] setting_switch_a_i,
  input wire [7:0] setting_switch_b_i,
  input wire [3:0] micro_sel_i,
  input wire [3:0] run_cur_sel_i,
  input wire [3:0] stop_cur_sel_i,
  // front panel and memory requests
  input wire knob_step_i,
  input wire knob_dir_i,
  input wire mem_wr_req_i,
  // register port
  input wire [3:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  // decoded settings
  output reg cfg_valid_o,
  output reg [7:0] step_div_o,
  output reg [9:0] run_current_ma_o,
  output reg [6:0] stop_pct_o,
  output reg [15:0] baud_o,
  output reg delim_cr_o,
  output reg delim_lf_o,
  output reg origin_separate_o,
  // gated front panel and memory
  output reg knob_step_o,
  output reg knob_dir_o,
  output reg backlash_dir_o,
  output reg mem_wr_o,
  // scaled maximum speed
  output reg [SPEED_W+1:0] max_speed_o
);

  // -------------------------------------------------
  // decode tables
  // -------------------------------------------------
  function [7:0] div_of;
    input [3:0] code;
    begin
      case (code)
        4'h0: div_of = 8'h01;
        4'h1: div_of = 8'h02;
        4'h2: div_of = 8'h04;
        4'h3: div_of = 8'h05;
        4'h4: div_of = 8'h08;
        4'h5: div_of = 8'h0A;
        4'h6: div_of = 8'h14;
        4'h7: div_of = 8'h28;
        4'h8: div_of = 8'h50;
        4'h9: div_of = 8'h10;
        4'hA: div_of = 8'h19;
        4'hB: div_of = 8'h32;
        4'hC: div_of = 8'h64;
        4'hD: div_of = 8'h7D;
        4'hE: div_of = 8'hC8;
        default: div_of = 8'hFA;
      endcase
    end
  endfunction

  // current in milliamps
  function [9:0] run_ma_of;
    input [3:0] code;
    begin
      case (code)
        4'h0: run_ma_of = 10'h0E6;
        4'h1: run_ma_of = 10'h10E;
        4'h2: run_ma_of = 10'h12C;
        4'h3: run_ma_of = 10'h154;
        4'h4: run_ma_of = 10'h172;
        4'h5: run_ma_of = 10'h190;
        4'h6: run_ma_of = 10'h1B8;
        4'h7: run_ma_of = 10'h1D6;
        4'h8: run_ma_of = 10'h1FE;
        4'h9: run_ma_of = 10'h21C;
        4'hA: run_ma_of = 10'h244;
        4'hB: run_ma_of = 10'h262;
        4'hC: run_ma_of = 10'h28A;
        4'hD: run_ma_of = 10'h2A8;
        4'hE: run_ma_of = 10'h2C6;
        default: run_ma_of = 10'h2EE;
      endcase
    end
  endfunction

  function [6:0] stop_pct_of;
    input [3:0] code;
    begin
      case (code)
        4'h0: stop_pct_of = 7'h1B;
        4'h1: stop_pct_of = 7'h1F;
        4'h2: stop_pct_of = 7'h24;
        4'h3: stop_pct_of = 7'h28;
        4'h4: stop_pct_of = 7'h2D;
        4'h5: stop_pct_of = 7'h32;
        4'h6: stop_pct_of = 7'h36;
        4'h7: stop_pct_of = 7'h3A;
        4'h8: stop_pct_of = 7'h3E;
        4'h9: stop_pct_of = 7'h42;
        4'hA: stop_pct_of = 7'h46;
        4'hB: stop_pct_of = 7'h4A;
        4'hC: stop_pct_of = 7'h4E;
        4'hD: stop_pct_of = 7'h52;
        4'hE: stop_pct_of = 7'h56;
        default: stop_pct_of = 7'h5A;
      endcase
    end
  endfunction

  // -------------------------------------------------
  // strobe decode
  // -------------------------------------------------
  // one write decode shared by every writable index
  function wr_hit;
    input wr;
    input [3:0] addr;
    input [3:0] idx;
    begin
      wr_hit = wr && (addr == idx);
    end
  endfunction

  // -------------------------------------------------
  // power-up capture
  // -------------------------------------------------
  reg [7:0] swa_reg;
  reg [7:0] swb_reg;
  reg [3:0] micro_reg;
  reg [3:0] run_reg;
  reg [3:0] stop_reg;

  // no path updates these after cfg_valid_o rises: a powered
  // change of a switch is deliberately invisible
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      cfg_valid_o <= 1'b0;
      swa_reg <= 8'h00;
      swb_reg <= 8'h00;
      micro_reg <= 4'h0;
      run_reg <= 4'h0;
      stop_reg <= `STOP_CODE_DEFAULT;
    end else if (!cfg_valid_o) begin
      cfg_valid_o <= 1'b1;
      // reserved positions masked here so they never reach a decode
      swa_reg <= setting_switch_a_i & `SWA_KEEP_MASK;
      swb_reg <= setting_switch_b_i & `SWB_KEEP_MASK;
      micro_reg <= micro_sel_i;
      run_reg <= run_cur_sel_i;
      stop_reg <= stop_cur_sel_i;
    end
  end

  // -------------------------------------------------
  // decoded outputs
  // -------------------------------------------------
  wire [1:0] baud_sel = {swa_reg[`SWA_BAUD1], swa_reg[`SWA_BAUD2]};
  wire [1:0] delim_sel = {swa_reg[`SWA_DELIM1], swa_reg[`SWA_DELIM2]};
  reg [15:0] baud_next;

  always @* begin
    case (baud_sel)
      2'h0: baud_next = 16'h12C0;
      2'h1: baud_next = 16'h2580;
      2'h2: baud_next = 16'h4B00;
      default: baud_next = 16'h9600;
    endcase
  end

  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      step_div_o <= 8'h00;
      run_current_ma_o <= 10'h000;
      stop_pct_o <= 7'h00;
      baud_o <= 16'h0000;
      delim_cr_o <= 1'b0;
      delim_lf_o <= 1'b0;
      origin_separate_o <= 1'b0;
    end else begin
      step_div_o <= div_of(micro_reg);
      run_current_ma_o <= run_ma_of(run_reg);
      stop_pct_o <= stop_pct_of(stop_reg);
      baud_o <= baud_next;
      delim_cr_o <= ~delim_sel[1];
      delim_lf_o <= ~delim_sel[0];
      origin_separate_o <= swb_reg[`SWB_ORIGIN_POL];
    end
  end

  // -------------------------------------------------
  // knob and memory gating
  // -------------------------------------------------
  wire mem_protect = swa_reg[`SWA_MEM_PROTECT];
  wire knob_lock = swa_reg[`SWA_KNOB_LOCK];
  wire knob_rev = swb_reg[`SWB_KNOB_REV];
  wire backlash_rev = swb_reg[`SWB_BACKLASH_REV];
  // before capture the protect bit is unknown, so a request
  // in that one cycle is refused rather than guessed
  wire refuse_now = mem_wr_req_i & (mem_protect | ~cfg_valid_o);

  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      knob_step_o <= 1'b0;
      knob_dir_o <= 1'b0;
      backlash_dir_o <= 1'b0;
      mem_wr_o <= 1'b0;
    end else begin
      // knob stays dead until settings are captured
      knob_step_o <= knob_step_i & cfg_valid_o & ~knob_lock;
      knob_dir_o <= knob_dir_i ^ knob_rev;
      backlash_dir_o <= knob_dir_i ^ backlash_rev;
      mem_wr_o <= mem_wr_req_i & ~refuse_now;
    end
  end

  // -------------------------------------------------
  // maximum speed scaling
  // -------------------------------------------------
  reg [SPEED_W-1:0] speed_base_reg;
  reg [SPEED_W+1:0] speed_num;
  reg [SPEED_W+1:0] speed_next;
  wire speed_boost = swb_reg[`SWB_BOOST];
  wire speed_slow = swb_reg[`SWB_SLOW];
  // divisor sized to the numerator so the quotient is not widened
  localparam [SPEED_W+1:0] SLOW_DIV = {{(SPEED_W-3){1'b0}}, `SPEED_SLOW_DIV};

  // numerator is twice or three times the base, so halving gives
  // x1 exactly or x1.5 with truncation, and /20 gives x0.1 or x0.15 with truncation
  always @* begin
    if (speed_boost)
      speed_num = {1'b0, speed_base_reg, 1'b0} + {2'b00, speed_base_reg};
    else
      speed_num = {1'b0, speed_base_reg, 1'b0};
    if (speed_slow)
      speed_next = speed_num / SLOW_DIV;
    else
      speed_next = speed_num >> 1;
  end

  always @(posedge core_clk_i) begin
    if (!rstn_i)
      max_speed_o <= {(SPEED_W+2){1'b0}};
    else
      max_speed_o <= speed_next;
  end

  // -------------------------------------------------
  // register port
  // -------------------------------------------------
  reg refused_reg;
  reg [31:0] rdata_next;

  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      speed_base_reg <= {SPEED_W{1'b0}};
      refused_reg <= 1'b0;
    end else begin
      if (wr_hit(reg_wr_i, reg_addr_i, `REG_SPEED_BASE))
        speed_base_reg <= reg_wdata_i[SPEED_W-1:0];
      // set beats a write-one clear in the same cycle
      if (refuse_now)
        refused_reg <= 1'b1;
      else if (wr_hit(reg_wr_i, reg_addr_i, `REG_STATUS) && reg_wdata_i[0])
        refused_reg <= 1'b0;
    end
  end

  // unmapped indices read as zero
  always @* begin
    case (reg_addr_i)
      `REG_SWITCH: rdata_next = {15'h0000, cfg_valid_o, swb_reg, swa_reg};
      `REG_SELECT: rdata_next = {20'h00000, stop_reg, run_reg, micro_reg};
      `REG_DECODE: rdata_next = {7'h00, stop_pct_o, run_current_ma_o, step_div_o};
      `REG_SPEED_BASE: rdata_next = {{(32-SPEED_W){1'b0}}, speed_base_reg};
      `REG_SPEED_OUT: rdata_next = {{(30-SPEED_W){1'b0}}, max_speed_o};
      `REG_STATUS: rdata_next = {31'h00000000, refused_reg};
      default: rdata_next = 32'h00000000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always @(posedge core_clk_i) begin
    if (!rstn_i)
      reg_rdata_o <= 32'h00000000;
    else if (reg_rd_i)
      reg_rdata_o <= rdata_next;
    else
      reg_rdata_o <= 32'h00000000;
  end

endmodule // positioner_switch_config_decoder
`default_nettype wire

// file: verif/positioner_cfg_sva.sv
// Purpose: port-level checks of the positioner switch configuration decoder
// Assumes: settings latch at the first edge after reset release
// Notes: keeps its own copy of the captured switch banks
`timescale 1ns/1ps
`default_nettype none
module positioner_cfg_sva (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // inputs watched
  input wire logic [7:0] setting_switch_a_i,
  input wire logic [7:0] setting_switch_b_i,
  input wire logic knob_step_i,
  input wire logic knob_dir_i,
  input wire logic mem_wr_req_i,
  // outputs watched
  input wire logic cfg_valid_o,
  input wire logic [15:0] baud_o,
  input wire logic delim_cr_o,
  input wire logic delim_lf_o,
  input wire logic origin_separate_o,
  input wire logic knob_step_o,
  input wire logic knob_dir_o,
  input wire logic backlash_dir_o,
  input wire logic mem_wr_o
);
  logic [7:0] cap_a;
  logic [7:0] cap_b;
  // later switch moves must not reach this copy
  always @(posedge core_clk_i) begin
    if (rstn_i && !cfg_valid_o) begin
      cap_a <= setting_switch_a_i;
      cap_b <= setting_switch_b_i;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  a_valid_hold: assert property (cfg_valid_o |=> cfg_valid_o)
    else $error("valid dropped while powered");
  a_knob_lock: assert property (knob_step_o |-> $past(knob_step_i) && !cap_a[7])
    else $error("knob step passed while locked");
  a_knob_dir: assert property (cfg_valid_o |=> knob_dir_o == ($past(knob_dir_i) ^ cap_b[2]))
    else $error("knob direction wrong");
  a_backlash_dir: assert property (cfg_valid_o |=> backlash_dir_o == ($past(knob_dir_i) ^ cap_b[3]))
    else $error("backlash direction wrong");
  a_mem_protect: assert property (mem_wr_o |-> $past(mem_wr_req_i) && !cap_a[6])
    else $error("memory write passed while protected");
  a_mem_pass: assert property (cfg_valid_o && mem_wr_req_i && !cap_a[6] |=> mem_wr_o)
    else $error("memory write lost");
  a_baud_map: assert property (cfg_valid_o && $past(cfg_valid_o) |-> baud_o == (16'h12C0 << {cap_a[0], cap_a[1]}))
    else $error("baud rate wrong");
  a_delim_map: assert property (cfg_valid_o && $past(cfg_valid_o) |-> {delim_cr_o, delim_lf_o} == {~cap_a[2], ~cap_a[3]})
    else $error("delimiter wrong");
  a_origin_map: assert property (cfg_valid_o && $past(cfg_valid_o) |-> origin_separate_o == cap_b[4])
    else $error("origin polarity wrong");
endmodule // positioner_cfg_sva
`default_nettype wire

// file: verif/stage_far_side.sv
// Purpose: far side model of stage driver and position memory
// Assumes: decoder outputs are registered on core_clk_i
// Notes: counts net knob steps and accepted memory writes only
`timescale 1ns/1ps
`default_nettype none
module stage_far_side (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // decoder outputs
  input wire logic knob_step_i,
  input wire logic knob_dir_i,
  input wire logic mem_wr_i,
  // observed counts
  output var int pos_o,
  output var int wr_cnt_o
);
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      pos_o <= 0;
      wr_cnt_o <= 0;
    end else begin
      if (knob_step_i) pos_o <= knob_dir_i ? pos_o + 1 : pos_o - 1;
      if (mem_wr_i) wr_cnt_o <= wr_cnt_o + 1;
    end
  end
endmodule // stage_far_side
`default_nettype wire

// file: verif/tb_top.sv
// Purpose: self-checking bench of the positioner switch configuration decoder
// Assumes: one power-up per test, all selector codes covered
// Notes: expected values come from integer tables below
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk_i, rstn_i, knob_step_i, knob_dir_i, mem_wr_req_i, reg_wr_i, reg_rd_i;
  logic [7:0] setting_switch_a_i, setting_switch_b_i, ca, cb;
  logic [3:0] micro_sel_i, run_cur_sel_i, stop_cur_sel_i, reg_addr_i;
  logic [31:0] reg_wdata_i, rd;
  wire [31:0] reg_rdata_o;
  wire cfg_valid_o, delim_cr_o, delim_lf_o, origin_separate_o, knob_step_o, knob_dir_o, backlash_dir_o, mem_wr_o;
  wire [7:0] step_div_o;
  wire [9:0] run_current_ma_o;
  wire [6:0] stop_pct_o;
  wire [15:0] baud_o;
  wire [17:0] max_speed_o;
  int err_total, comparisons, seed, pos, wcnt, exp_pos, base, mc, rc, sc;
  int div_t[16] = '{1, 2, 4, 5, 8, 10, 20, 40, 80, 16, 25, 50, 100, 125, 200, 250};
  int run_t[16] = '{230, 270, 300, 340, 370, 400, 440, 470, 510, 540, 580, 610, 650, 680, 710, 750};
  int pct_t[16] = '{27, 31, 36, 40, 45, 50, 54, 58, 62, 66, 70, 74, 78, 82, 86, 90};
  positioner_switch_config_decoder #(.SPEED_W(16)) i_positioner_switch_config_decoder (.core_clk_i, .rstn_i,
    .setting_switch_a_i, .setting_switch_b_i, .micro_sel_i, .run_cur_sel_i, .stop_cur_sel_i, .knob_step_i,
    .knob_dir_i, .mem_wr_req_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .cfg_valid_o,
    .step_div_o, .run_current_ma_o, .stop_pct_o, .baud_o, .delim_cr_o, .delim_lf_o, .origin_separate_o,
    .knob_step_o, .knob_dir_o, .backlash_dir_o, .mem_wr_o, .max_speed_o);
  stage_far_side i_stage_far_side (.core_clk_i, .rstn_i, .knob_step_i(knob_step_o), .knob_dir_i(knob_dir_o),
    .mem_wr_i(mem_wr_o), .pos_o(pos), .wr_cnt_o(wcnt));
  initial begin
    core_clk_i = 1'h0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  task chk(input logic [31:0] got, input logic [31:0] e);
    comparisons++;
    if (got !== e) begin
      err_total++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, e);
    end
  endtask
  // one register access; read data lands in rd
  task rw(input logic [3:0] a, input logic [31:0] d, input bit wr);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= wr;
    reg_rd_i <= !wr;
    @(posedge core_clk_i);
    reg_wr_i <= 1'h0;
    reg_rd_i <= 1'h0;
    #1 rd = reg_rdata_o;
  endtask
  task check_dec;
    chk(step_div_o, div_t[mc]);
    chk(run_current_ma_o, run_t[rc]);
    chk(stop_pct_o, pct_t[sc]);
    chk(baud_o, 32'h12C0 << {ca[0], ca[1]});
    chk({delim_cr_o, delim_lf_o}, {~ca[2], ~ca[3]});
    chk(origin_separate_o, cb[4]);
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge core_clk_i);
    err_total++;
    print_verdict;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 11855;
    {knob_step_i, knob_dir_i, mem_wr_req_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk_i);
      rstn_i <= 1'h0;
      ca = $random(seed);
      cb = $random(seed);
      {mc, rc, sc} = {i, i, 15 - i};
      setting_switch_a_i <= ca;
      setting_switch_b_i <= cb;
      {micro_sel_i, run_cur_sel_i, stop_cur_sel_i} <= {mc[3:0], rc[3:0], sc[3:0]};
      repeat (16) @(posedge core_clk_i);
      rstn_i <= 1'h1;
      @(posedge core_clk_i);
      #1 chk(cfg_valid_o, 32'h1);
      chk(stop_pct_o, 32'h32);
      repeat (2) @(posedge core_clk_i);
      #1 check_dec;
      rw(4'h0, 32'h0, 0);
      chk(rd, {15'h0, 1'h1, cb & 8'h1F, ca & 8'hCF});
      // moved switches must be ignored until the next power-up
      setting_switch_a_i <= ~ca;
      setting_switch_b_i <= ~cb;
      micro_sel_i <= ~mc[3:0];
      repeat (4) @(posedge core_clk_i);
      #1 check_dec;
      exp_pos = 0;
      for (int j = 0; j < 2; j++) begin
        @(posedge core_clk_i);
        knob_step_i <= 1'h1;
        knob_dir_i <= j[0];
        @(posedge core_clk_i);
        knob_step_i <= 1'h0;
        #1 chk(knob_step_o, !ca[7]);
        chk(knob_dir_o, j[0] ^ cb[2]);
        chk(backlash_dir_o, j[0] ^ cb[3]);
        if (!ca[7]) exp_pos += (j[0] ^ cb[2]) ? 1 : -1;
      end
      @(posedge core_clk_i);
      mem_wr_req_i <= 1'h1;
      @(posedge core_clk_i);
      mem_wr_req_i <= 1'h0;
      #1 chk(mem_wr_o, !ca[6]);
      chk(pos, exp_pos);
      rw(4'h5, 32'h0, 0);
      chk(rd, ca[6]);
      chk(wcnt, !ca[6]);
      rw(4'h5, 32'h1, 1);
      rw(4'h5, 32'h0, 0);
      chk(rd, 32'h0);
      base = $random(seed) & 32'hFFFF;
      rw(4'h3, base, 1);
      repeat (2) @(posedge core_clk_i);
      #1 chk(max_speed_o, cb[1] ? (cb[0] ? base * 3 / 20 : base / 10) : (cb[0] ? base * 3 / 2 : base));
      $display("power-up test %0d done", i);
    end
    print_verdict;
  end
endmodule // tb_top
bind positioner_switch_config_decoder positioner_cfg_sva i_positioner_cfg_sva (.core_clk_i, .rstn_i,
  .setting_switch_a_i, .setting_switch_b_i, .knob_step_i, .knob_dir_i, .mem_wr_req_i, .cfg_valid_o, .baud_o,
  .delim_cr_o, .delim_lf_o, .origin_separate_o, .knob_step_o, .knob_dir_o, .backlash_dir_o, .mem_wr_o);
`default_nettype wire
